// [pkg/psl_pkg.sv]
// Purpose: Constants and carrier types for the positioning status and speed limit block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Widths in reference units, speeds in 1 mm/s steps
// What this block does
// - Done asserts when error below done width
// - Done only produced during position control
// - Done timing: plain, filtered zero, raw zero
// - Outputs high means closed contact, active
// - Near asserts while error below near width
// - Limited output while speed reaches active limit
// - Speed limit applies only in force control
// - Source select: internal setting or external reference
// - Internal limit 0..10000, default 10000, immediate
// - Default ceiling: min of max speed, setting
// - Alternate ceiling: min of overspeed, setting
// - Setting above selected ceiling falls back to ceiling
// - External mode uses option-side limit reference
package psl_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WIDTH_W = 31;
  localparam int SPEED_W = 16;
  localparam int COUNT_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_DONE_WIDTH = 8'h00;
  localparam logic [7:0] OFF_NEAR_WIDTH = 8'h04;
  localparam logic [7:0] OFF_SPEED_LIMIT = 8'h08;
  localparam logic [7:0] OFF_CFG_PENDING = 8'h0c;
  localparam logic [7:0] OFF_CFG_ACTIVE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_POS_ERROR = 8'h18;
  localparam logic [7:0] OFF_RESTART = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions and encodings
  // ----------------------------------------------------------------
  localparam int CFG_TIMING_LSB = 0;
  localparam int CFG_SOURCE_BIT = 4;
  localparam int CFG_CEILING_BIT = 8;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_NEAR_BIT = 1;
  localparam int ST_LIMITED_BIT = 2;
  localparam logic [1:0] TIMING_PLAIN = 2'h0;
  localparam logic [1:0] TIMING_FILTERED = 2'h1;
  localparam logic [1:0] TIMING_RAW = 2'h2;

  // ----------------------------------------------------------------
  // Values after reset, and the top of the internal speed limit setting range
  // ----------------------------------------------------------------
  localparam logic [WIDTH_W-1:0] RST_DONE_WIDTH = 31'h00000007;
  localparam logic [WIDTH_W-1:0] RST_NEAR_WIDTH = 31'h40000000;
  localparam logic [SPEED_W-1:0] RST_SPEED_LIMIT = 16'h2710;
  localparam logic [SPEED_W-1:0] MAX_SPEED_SETTING = 16'h2710;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] timing;
    logic source_ext;
    logic ceiling_ovs;
  } psl_cfg_t;

  localparam psl_cfg_t RST_CFG = '{timing: 2'h0, source_ext: 1'b0, ceiling_ovs: 1'b0};

  typedef struct packed {
    logic position_mode;
    logic [COUNT_W-1:0] ref_count;
    logic [COUNT_W-1:0] fb_count;
    logic ref_filtered_zero;
    logic ref_input_zero;
  } psl_pos_in_t;

  typedef struct packed {
    logic force_mode;
    logic [SPEED_W-1:0] motor_speed_abs;
    logic [SPEED_W-1:0] max_motor_speed;
    logic [SPEED_W-1:0] overspeed_speed;
    logic [SPEED_W-1:0] ext_speed_limit;
  } psl_spd_in_t;

  typedef struct packed {
    logic position_done_out;
    logic position_near_out;
    logic speed_limited_out;
    logic [SPEED_W-1:0] active_limit;
  } psl_out_t;

endpackage

// [verilog/psl_core.sv]
// Purpose: Position done, position near and speed limit indication with APB settings
// Assumes: Reference and feedback counts come from logic on pclk
// Notes: Outputs follow inputs with one cycle of latency
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module psl_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire psl_pkg::psl_pos_in_t pos_in,
  input wire psl_pkg::psl_spd_in_t spd_in,
  output psl_pkg::psl_out_t status_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [psl_pkg::WIDTH_W-1:0] done_width;
    logic [psl_pkg::WIDTH_W-1:0] near_width;
    logic [psl_pkg::SPEED_W-1:0] internal_speed_limit;
    psl_pkg::psl_cfg_t cfg_pending;
    psl_pkg::psl_cfg_t cfg_active;
    psl_pkg::psl_out_t outs;
    logic [32:0] err_mag;
    logic [31:0] rdata;
    logic slverr;
  } psl_state_t;

  psl_state_t st;
  psl_state_t next_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Decode used only by the error answer; the read mux decodes paddr itself
  function automatic logic addr_mapped(input logic [7:0] a);
    begin
      addr_mapped = (a == psl_pkg::OFF_DONE_WIDTH) || (a == psl_pkg::OFF_NEAR_WIDTH) ||
                    (a == psl_pkg::OFF_SPEED_LIMIT) || (a == psl_pkg::OFF_CFG_PENDING) ||
                    (a == psl_pkg::OFF_CFG_ACTIVE) || (a == psl_pkg::OFF_STATUS) ||
                    (a == psl_pkg::OFF_POS_ERROR) || (a == psl_pkg::OFF_RESTART);
    end
  endfunction

  function automatic logic [31:0] cfg_word(input psl_pkg::psl_cfg_t c);
    logic [31:0] w;
    begin
      w = 32'h00000000;
      w[psl_pkg::CFG_TIMING_LSB +: 2] = c.timing;
      w[psl_pkg::CFG_SOURCE_BIT] = c.source_ext;
      w[psl_pkg::CFG_CEILING_BIT] = c.ceiling_ovs;
      cfg_word = w;
    end
  endfunction

  function automatic logic [psl_pkg::SPEED_W-1:0] min16(input logic [psl_pkg::SPEED_W-1:0] a,
                                                         input logic [psl_pkg::SPEED_W-1:0] b);
    begin
      min16 = (a < b) ? a : b;
    end
  endfunction

  // ----------------------------------------------------------------
  // Combinational position and speed terms
  // ----------------------------------------------------------------
  logic [32:0] err_signed;
  logic [32:0] err_mag;
  logic timing_ok;
  logic done_now;
  logic near_now;
  logic [psl_pkg::SPEED_W-1:0] ceiling;
  logic [psl_pkg::SPEED_W-1:0] limit_now;
  logic limited_now;
  logic wr_en;
  logic rd_setup;

  // Error kept at 33 bits so the subtraction cannot wrap
  assign err_signed = {pos_in.ref_count[31], pos_in.ref_count} - {pos_in.fb_count[31], pos_in.fb_count};
  assign err_mag = err_signed[32] ? (33'h000000000 - err_signed) : err_signed;

  // Timing qualifier comes from the restart-latched copy only
  always_comb begin
    case (st.cfg_active.timing)
      psl_pkg::TIMING_FILTERED: timing_ok = pos_in.ref_filtered_zero;
      psl_pkg::TIMING_RAW: timing_ok = pos_in.ref_input_zero;
      default: timing_ok = 1'b1;
    endcase
  end

  // Widths are read live, so a write counts from the next cycle
  assign done_now = pos_in.position_mode && timing_ok && (err_mag < {2'h0, st.done_width});
  assign near_now = err_mag < {2'h0, st.near_width};

  // Ceiling is max motor speed or overspeed speed; a setting above it falls back to it
  assign ceiling = st.cfg_active.ceiling_ovs ? spd_in.overspeed_speed : spd_in.max_motor_speed;

  always_comb begin
    if (st.cfg_active.source_ext) begin
      limit_now = spd_in.ext_speed_limit;
    end else begin
      limit_now = min16(ceiling, st.internal_speed_limit);
    end
  end

  // Clamp only exists in force control; elsewhere it never shows
  assign limited_now = spd_in.force_mode && (spd_in.motor_speed_abs >= limit_now);

  // ----------------------------------------------------------------
  // APB strobes
  // ----------------------------------------------------------------
  // Zero wait: the access phase always completes in one cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.err_mag = err_mag;
    next_st.outs.position_done_out = done_now;
    next_st.outs.position_near_out = near_now;
    next_st.outs.speed_limited_out = limited_now;
    next_st.outs.active_limit = limit_now;
    if (wr_en) begin
      case (paddr)
        psl_pkg::OFF_DONE_WIDTH: next_st.done_width = pwdata[psl_pkg::WIDTH_W-1:0];
        psl_pkg::OFF_NEAR_WIDTH: next_st.near_width = pwdata[psl_pkg::WIDTH_W-1:0];
        psl_pkg::OFF_SPEED_LIMIT: begin
          // Settings above the range clamp to the top of it
          if (pwdata[15:0] > psl_pkg::MAX_SPEED_SETTING) begin
            next_st.internal_speed_limit = psl_pkg::MAX_SPEED_SETTING;
          end else begin
            next_st.internal_speed_limit = pwdata[15:0];
          end
        end
        psl_pkg::OFF_CFG_PENDING: begin
          next_st.cfg_pending.timing = pwdata[psl_pkg::CFG_TIMING_LSB +: 2];
          next_st.cfg_pending.source_ext = pwdata[psl_pkg::CFG_SOURCE_BIT];
          next_st.cfg_pending.ceiling_ovs = pwdata[psl_pkg::CFG_CEILING_BIT];
        end
        psl_pkg::OFF_RESTART: begin
          if (pwdata[0]) begin
            next_st.cfg_active = st.cfg_pending;
          end
        end
        default: begin
        end
      endcase
    end
    // Read data is captured at setup so it is stable in the access phase
    if (rd_setup) begin
      next_st.slverr = !addr_mapped(paddr);
      case (paddr)
        psl_pkg::OFF_DONE_WIDTH: next_st.rdata = {1'b0, st.done_width};
        psl_pkg::OFF_NEAR_WIDTH: next_st.rdata = {1'b0, st.near_width};
        psl_pkg::OFF_SPEED_LIMIT: next_st.rdata = {16'h0000, st.internal_speed_limit};
        psl_pkg::OFF_CFG_PENDING: next_st.rdata = cfg_word(st.cfg_pending);
        psl_pkg::OFF_CFG_ACTIVE: next_st.rdata = cfg_word(st.cfg_active);
        psl_pkg::OFF_STATUS: begin
          next_st.rdata = {st.outs.active_limit, 13'h0000,
                           st.outs.speed_limited_out, st.outs.position_near_out, st.outs.position_done_out};
        end
        psl_pkg::OFF_POS_ERROR: next_st.rdata = (st.err_mag > 33'h0ffffffff) ? 32'hffffffff : st.err_mag[31:0];
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.done_width <= psl_pkg::RST_DONE_WIDTH;
      st.near_width <= psl_pkg::RST_NEAR_WIDTH;
      st.internal_speed_limit <= psl_pkg::RST_SPEED_LIMIT;
      st.cfg_pending <= psl_pkg::RST_CFG;
      st.cfg_active <= psl_pkg::RST_CFG;
      st.outs <= '0;
      st.err_mag <= 33'h000000000;
      st.rdata <= 32'h00000000;
      st.slverr <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Status and read data straight from flip-flops; pslverr gated by psel and penable
  assign status_out = st.outs;
  assign prdata = st.rdata;
  assign pslverr = st.slverr && psel && penable;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_width_write(logic [7:0] off);
    psel && penable && pwrite && (paddr == off);
  endsequence

  sequence s_restart_write;
    psel && penable && pwrite && (paddr == psl_pkg::OFF_RESTART) && pwdata[0];
  endsequence

  // Reset sampled low at the release edge keeps a flushed output from firing
  a_done_follows: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && pos_in.position_mode && (st.cfg_active.timing == psl_pkg::TIMING_PLAIN) &&
    (err_mag < {2'h0, st.done_width}) |=> status_out.position_done_out)
    else $error("done output missing inside width");

  a_done_posmode: assert property (@(posedge pclk) disable iff (!presetn)
    !pos_in.position_mode |=> !status_out.position_done_out)
    else $error("done asserted outside position control");

  a_done_timing: assert property (@(posedge pclk) disable iff (!presetn)
    (st.cfg_active.timing == psl_pkg::TIMING_RAW) && !pos_in.ref_input_zero |=> !status_out.position_done_out)
    else $error("done asserted while raw reference nonzero");

  a_near_follows: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && (err_mag < {2'h0, st.near_width}) |=> status_out.position_near_out)
    else $error("near output missing");

  a_width_immed: assert property (@(posedge pclk) disable iff (!presetn)
    s_width_write(psl_pkg::OFF_DONE_WIDTH) |=> st.done_width == $past(pwdata[30:0]))
    else $error("done width write not applied");

  a_limit_force: assert property (@(posedge pclk) disable iff (!presetn)
    !spd_in.force_mode |=> !status_out.speed_limited_out)
    else $error("limited output outside force control");

  a_limit_reach: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && spd_in.force_mode && (spd_in.motor_speed_abs >= limit_now) |=> status_out.speed_limited_out)
    else $error("limited output missing at limit");

  a_limit_ceil: assert property (@(posedge pclk) disable iff (!presetn)
    !st.cfg_active.source_ext |-> limit_now <= ceiling && limit_now <= st.internal_speed_limit)
    else $error("internal limit above ceiling or setting");

  a_limit_ext: assert property (@(posedge pclk) disable iff (!presetn)
    st.cfg_active.source_ext |=> status_out.active_limit == $past(spd_in.ext_speed_limit))
    else $error("external limit not used");

  a_cfg_restart: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable && pwrite && (paddr == psl_pkg::OFF_RESTART) && pwdata[0]) |=> $stable(st.cfg_active))
    else $error("active config changed without restart");

  a_speed_range: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |-> st.internal_speed_limit <= psl_pkg::MAX_SPEED_SETTING)
    else $error("speed limit setting out of range");

  // Opposite directions, so a stuck-high output is caught as well
  a_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (err_mag >= {2'h0, st.done_width}) |=> !status_out.position_done_out)
    else $error("done asserted with error at or above width");

  a_filt_timing: assert property (@(posedge pclk) disable iff (!presetn)
    (st.cfg_active.timing == psl_pkg::TIMING_FILTERED) && !pos_in.ref_filtered_zero
    |=> !status_out.position_done_out)
    else $error("done asserted while filtered reference nonzero");

  a_near_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (err_mag >= {2'h0, st.near_width}) |=> !status_out.position_near_out)
    else $error("near asserted with error at or above width");

  a_near_immed: assert property (@(posedge pclk) disable iff (!presetn)
    s_width_write(psl_pkg::OFF_NEAR_WIDTH) |=> st.near_width == $past(pwdata[30:0]))
    else $error("near width write not applied");

  a_limit_clear: assert property (@(posedge pclk) disable iff (!presetn)
    spd_in.force_mode && (spd_in.motor_speed_abs < limit_now) |=> !status_out.speed_limited_out)
    else $error("limited output while below limit");

  a_cfg_copy: assert property (@(posedge pclk) disable iff (!presetn)
    s_restart_write |=> st.cfg_active == $past(st.cfg_pending))
    else $error("restart did not copy pending config");

endmodule

// [verification/psl_host.sv]
// Purpose: Host controller model issuing position references to the block
// Assumes: Bench states the wanted counts and zero flags, host launches them on pclk
// Notes: One register stage, like a host output latch
`timescale 1ns/1ns
module psl_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire psl_pkg::psl_pos_in_t want,
  output psl_pkg::psl_pos_in_t pos_out
);
  // Reference latch, cleared at reset so no stale count reaches the drive
  // Status outputs are taken as already allocated to pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_out <= '0;
    end else begin
      pos_out <= want;
    end
  end
endmodule

// [verification/psl_core_bench.sv]
// Purpose: Self-checking bench for the position status and speed limit block
// Assumes: Zero wait APB slave, status one edge after inputs
// Notes: Reset defaults first, then table of plain cases, then width, limit, config, refusal and reset cases
`timescale 1ns/1ns
module psl_core_bench;
  typedef struct {
    logic m;
    logic [31:0] rc, fc;
    logic f;
    logic [15:0] s, mx;
    logic [2:0] fl;
    logic [15:0] lim;
  } psl_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  psl_pkg::psl_pos_in_t want, pos;
  psl_pkg::psl_spd_in_t spd;
  psl_pkg::psl_out_t st;
  int num_errors = 0;
  int cmp_count = 0;
  psl_row_t rows[6];

  psl_host host (.pclk(pclk), .presetn(presetn), .want(want), .pos_out(pos));
  psl_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pos_in(pos), .spd_in(spd), .status_out(st));

  // ----------------------------------------------------------------
  // Clock, checking and closing
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole run is under two hundred cycles, so this only trips on a hang
  initial begin
    #50000;
    num_errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // APB master and stimulus helpers
  // ----------------------------------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Host needs one edge, the block one more, one spare edge, then look mid-cycle
  task apply(input logic m, input logic [31:0] rc, fc, input logic [1:0] z, input logic f,
             input logic [15:0] s, mx, ov, ex);
    @(posedge pclk);
    want <= '{m, rc, fc, z[1], z[0]};
    spd <= '{f, s, mx, ov, ex};
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  function automatic logic [31:0] stat();
    return {13'h0000, st.position_done_out, st.position_near_out, st.speed_limited_out, st.active_limit};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    want = '0;
    spd = '0;
    rows = '{'{1, 32'h64, 32'h5e, 1, 16'h01f4, 16'h0bb8, 3'b110, 16'h0bb8},
             '{1, 32'h64, 32'h5d, 1, 16'h0bb8, 16'h0bb8, 3'b011, 16'h0bb8},
             '{1, 32'h5e, 32'h64, 0, 16'h2328, 16'h0bb8, 3'b110, 16'h0bb8},
             '{0, 32'h05, 32'h05, 1, 16'h2710, 16'h2ee0, 3'b011, 16'h2710},
             '{1, 32'h00, 32'h40000000, 1, 16'h270f, 16'h2ee0, 3'b000, 16'h2710},
             '{1, 32'h00, 32'h3fffffff, 1, 16'h2710, 16'h2ee0, 3'b011, 16'h2710}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Defaults after reset
    apb(0, 8'h00, 0); chk(q, 32'h00000007);
    apb(0, 8'h04, 0); chk(q, 32'h40000000);
    apb(0, 8'h08, 0); chk(q, 32'h00002710);
    apb(0, 8'h10, 0); chk(q, 32'h00000000);
    $display("reset values test done");
    // Table of plain cases at default configuration
    foreach (rows[i]) begin
      apply(rows[i].m, rows[i].rc, rows[i].fc, 2'h0, rows[i].f, rows[i].s, rows[i].mx, 16'h0, 16'h0);
      chk(stat(), {13'h0000, rows[i].fl, rows[i].lim});
    end
    $display("table test done");
    // Narrow widths, near kept above done; a zero done width never completes
    apb(1, 8'h00, 32'h14);
    apb(1, 8'h04, 32'h1e);
    apply(1, 32'h10f, 32'h100, 2'h0, 0, 16'h0, 16'h0bb8, 16'h0, 16'h0);
    chk(stat(), {13'h0000, 3'b110, 16'h0bb8});
    apply(1, 32'h100, 32'h119, 2'h0, 0, 16'h0, 16'h0bb8, 16'h0, 16'h0);
    chk(stat(), {13'h0000, 3'b010, 16'h0bb8});
    apb(0, 8'h18, 0); chk(q, 32'h00000019);
    apb(0, 8'h14, 0); chk(q, 32'h0bb80002);
    apb(1, 8'h00, 32'h0);
    apply(1, 32'h5, 32'h5, 2'h0, 0, 16'h0, 16'h0bb8, 16'h0, 16'h0);
    chk(stat(), {13'h0000, 3'b010, 16'h0bb8});
    apb(1, 8'h00, 32'h7);
    $display("width test done");
    // Internal limit: clamp on write, exact boundary of the compare
    apb(1, 8'h08, 32'h4e20);
    apb(0, 8'h08, 0); chk(q, 32'h00002710);
    apb(1, 8'h08, 32'h01f4);
    apply(0, 32'h5, 32'h5, 2'h0, 1, 16'h01f4, 16'h0bb8, 16'h0, 16'h0);
    chk(stat(), {13'h0000, 3'b011, 16'h01f4});
    apply(0, 32'h5, 32'h5, 2'h0, 1, 16'h01f3, 16'h0bb8, 16'h0, 16'h0);
    chk(stat(), {13'h0000, 3'b010, 16'h01f4});
    apb(1, 8'h08, 32'h2710);
    $display("speed limit test done");
    // Pending config stays idle until restart
    apb(1, 8'h0c, 32'h101);
    apb(0, 8'h10, 0); chk(q, 32'h0);
    apply(1, 32'h5, 32'h5, 2'h0, 1, 16'h0fa0, 16'h0bb8, 16'h1388, 16'h0);
    chk(stat(), {13'h0000, 3'b111, 16'h0bb8});
    apb(1, 8'h1c, 32'h1);
    apb(0, 8'h10, 0); chk(q, 32'h101);
    apply(1, 32'h5, 32'h5, 2'h0, 1, 16'h0fa0, 16'h0bb8, 16'h1388, 16'h0);
    chk(stat(), {13'h0000, 3'b010, 16'h1388});
    apply(1, 32'h5, 32'h5, 2'b10, 1, 16'h0fa0, 16'h0bb8, 16'h1388, 16'h0);
    chk(stat(), {13'h0000, 3'b110, 16'h1388});
    // Raw reference qualifier with external limit source
    apb(1, 8'h0c, 32'h12);
    apb(1, 8'h1c, 32'h1);
    apply(1, 32'h5, 32'h5, 2'b10, 1, 16'h04d2, 16'h0bb8, 16'h1388, 16'h04d2);
    chk(stat(), {13'h0000, 3'b011, 16'h04d2});
    apply(1, 32'h5, 32'h5, 2'b01, 1, 16'h04d2, 16'h0bb8, 16'h1388, 16'h04d2);
    chk(stat(), {13'h0000, 3'b111, 16'h04d2});
    apb(0, 8'h0c, 0); chk(q, 32'h00000012);
    // Timing code 3 acts as plain; source returns to the internal setting
    apb(1, 8'h0c, 32'h3);
    apb(1, 8'h1c, 32'h1);
    apply(1, 32'h5, 32'h5, 2'h0, 1, 16'h04d2, 16'h0bb8, 16'h1388, 16'h04d2);
    chk(stat(), {13'h0000, 3'b110, 16'h0bb8});
    $display("config test done");
    // Refused accesses leave settings alone
    apb(1, 8'h20, 32'h0); chk({31'h0, e}, 32'h1);
    apb(1, 8'h14, 32'hffffffff);
    apb(0, 8'h00, 0); chk(q, 32'h7);
    $display("refusal test done");
    // Second reset in mid-run returns the defaults
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk); chk(stat(), 32'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h10, 0); chk(q, 32'h0);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule
